// [rail_seq_pkg.sv]
// Purpose: Shared constants and types for the rail sequencing block.
// Assumes: Commands arrive already decoded from the management bus.
// Notes: Unused register bits read as zero.
package rail_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] CMD_LOOP_TUNING = 8'hDF;
  localparam logic [7:0] CMD_RAIL_ORDER = 8'hE0;
  localparam logic [7:0] CMD_VOLTAGE_FOLLOW_SETUP = 8'hE1;
  localparam logic [7:0] CMD_EVENT_GROUP_SETUP = 8'hE2;

  ////////////////////////////////////////////////////////////////////////////
  // Loop tuning fields
  localparam int LOOP_ENABLE_BIT = 24;
  localparam int LOOP_RESIDUAL_LSB = 16;
  localparam int LOOP_RESIDUAL_W = 8;
  localparam int LOOP_GAIN_LSB = 0;
  localparam int LOOP_GAIN_W = 16;
  localparam logic [24:0] LOOP_TUNING_RESET = 25'h0000000;

  // Rail order fields
  localparam int PREQUEL_ENABLE_BIT = 15;
  localparam int PREQUEL_ID_LSB = 8;
  localparam int SEQUEL_ENABLE_BIT = 7;
  localparam int SEQUEL_ID_LSB = 0;
  localparam int RAIL_ID_W = 5;
  localparam logic [15:0] RAIL_ORDER_RESET = 16'h0000;

  // Voltage follow fields
  localparam int TRACK_ENABLE_BIT = 7;
  localparam int TRACK_RATIO_BIT = 2;
  localparam int TRACK_LIMIT_BIT = 1;
  localparam logic [2:0] VOLTAGE_FOLLOW_RESET = 3'h0;

  // Event group fields
  localparam int SETPOINT_RESPOND_BIT = 21;
  localparam int SETPOINT_GROUP_LSB = 16;
  localparam int OPERATION_RESPOND_BIT = 13;
  localparam int OPERATION_GROUP_LSB = 8;
  localparam int FAIL_IMMEDIATE_BIT = 5;
  localparam int FAIL_GROUP_LSB = 0;
  localparam logic [23:0] EVENT_GROUP_RESET = 24'h000000;

  // Turn-off delay counter width
  localparam int OFF_DELAY_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Inter-rail event bus
  typedef enum logic [2:0] {
    EV_POWER_GOOD,
    EV_POWER_DOWN,
    EV_POWER_FAIL,
    EV_SETPOINT,
    EV_OPERATION
  } event_kind_type;

  localparam int EVENT_KINDS = 5;

  typedef struct packed {
    event_kind_type kind;
    logic [4:0] data;
    logic share_peer;
  } bus_event_type;

endpackage : rail_seq_pkg

// [hold_timer.sv]
// Purpose: Down counter that delays a shutdown by a programmed count.
// Assumes: Same clock as the caller; load is sampled on start.
// Notes: A load of zero finishes on the cycle after start.
`timescale 1ns/1ns
`default_nettype none
module hold_timer #(
  parameter int W = 16
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Command
  input wire logic start,
  input wire logic abort,
  input wire logic [W-1:0] load,
  // Status
  output logic busy,
  output logic done
);

  logic [W-1:0] count;

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        count <= load;
        busy <= 1'b1;
      end else if (busy) begin
        if (count == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end

endmodule : hold_timer
`default_nettype wire

// [rail_sequence_group_config.sv]
// Purpose: Loop tuning, rail sequencing, tracking and group event logic.
// Assumes: Event bus and command port run on clk; control pin is async.
// Notes: Received events and local requests are one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
module rail_sequence_group_config
  import rail_seq_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Decoded management commands
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] cmd_wdata,
  output logic rd_valid,
  output logic [31:0] rd_data,
  output logic cmd_unmapped,
  // Local enable sources, chosen by the on/off configuration
  input wire logic ctrl_pin,
  input wire logic use_pin,
  input wire logic use_operation,
  input wire logic operation_on,
  // Identity and shared configuration
  input wire logic [4:0] own_rail_id,
  input wire logic share_member,
  input wire logic [OFF_DELAY_W-1:0] off_delay,
  // Event bus receive
  input wire logic rx_valid,
  input wire bus_event_type rx_event,
  // Event bus transmit and local broadcast requests
  input wire logic send_setpoint,
  input wire logic send_operation,
  input wire logic send_power_fail,
  output logic tx_valid,
  output bus_event_type tx_event,
  // Power stage control
  output logic output_on,
  output logic fast_off,
  output logic setpoint_hit,
  output logic operation_hit,
  // Loop and tracking settings
  output logic adaptive_loop_response,
  output logic [LOOP_RESIDUAL_W-1:0] loop_residual,
  output logic [LOOP_GAIN_W-1:0] loop_gain,
  output logic track_enable,
  output logic track_half_ratio,
  output logic track_limit_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage; only defined bits are kept
  logic [24:0] loop_tuning;
  logic [15:0] rail_order;
  logic [2:0] voltage_follow_setup;
  logic [23:0] event_group_setup;

  logic wr;
  assign wr = cmd_valid && cmd_write;
  always_ff @(posedge clk) begin
    if (rst) begin
      loop_tuning <= LOOP_TUNING_RESET;
    end else if (ce && wr && cmd_code == CMD_LOOP_TUNING) begin
      loop_tuning <= cmd_wdata[24:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rail_order <= RAIL_ORDER_RESET;
    end else if (ce && wr && cmd_code == CMD_RAIL_ORDER) begin
      // Gaps between fields are not stored
      rail_order <= cmd_wdata[15:0] & 16'h9F9F;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      voltage_follow_setup <= VOLTAGE_FOLLOW_RESET;
    end else if (ce && wr && cmd_code == CMD_VOLTAGE_FOLLOW_SETUP) begin
      voltage_follow_setup <= {cmd_wdata[TRACK_ENABLE_BIT],
                               cmd_wdata[TRACK_RATIO_BIT],
                               cmd_wdata[TRACK_LIMIT_BIT]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      event_group_setup <= EVENT_GROUP_RESET;
    end else if (ce && wr && cmd_code == CMD_EVENT_GROUP_SETUP) begin
      // Top byte is unused and never stored
      event_group_setup <= cmd_wdata[23:0] & 24'h3F3F3F;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, answered one cycle after the request
  logic [31:0] next_rd_data;
  logic next_unmapped;

  always_comb begin
    next_rd_data = 32'h00000000;
    next_unmapped = 1'b0;
    case (cmd_code)
      CMD_LOOP_TUNING: next_rd_data = {7'h00, loop_tuning};
      CMD_RAIL_ORDER: next_rd_data = {16'h0000, rail_order};
      CMD_VOLTAGE_FOLLOW_SETUP: begin
        next_rd_data[TRACK_ENABLE_BIT] = voltage_follow_setup[2];
        next_rd_data[TRACK_RATIO_BIT] = voltage_follow_setup[1];
        next_rd_data[TRACK_LIMIT_BIT] = voltage_follow_setup[0];
      end
      CMD_EVENT_GROUP_SETUP: next_rd_data = {8'h00, event_group_setup};
      default: next_unmapped = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data <= 32'h00000000;
      cmd_unmapped <= 1'b0;
    end else if (ce) begin
      rd_valid <= cmd_valid && !cmd_write;
      cmd_unmapped <= cmd_valid && next_unmapped;
      if (cmd_valid && !cmd_write) begin
        rd_data <= next_rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field views
  logic pre_en, seq_en, sp_respond, op_respond, pf_immediate;
  logic [4:0] pre_id, seq_id, sp_group, op_group, pf_group;
  assign pre_en = rail_order[PREQUEL_ENABLE_BIT];
  assign seq_en = rail_order[SEQUEL_ENABLE_BIT];
  assign pre_id = rail_order[PREQUEL_ID_LSB +: RAIL_ID_W];
  assign seq_id = rail_order[SEQUEL_ID_LSB +: RAIL_ID_W];
  assign sp_group = event_group_setup[SETPOINT_GROUP_LSB +: RAIL_ID_W];
  assign op_group = event_group_setup[OPERATION_GROUP_LSB +: RAIL_ID_W];
  assign pf_group = event_group_setup[FAIL_GROUP_LSB +: RAIL_ID_W];
  assign sp_respond = event_group_setup[SETPOINT_RESPOND_BIT];
  assign op_respond = event_group_setup[OPERATION_RESPOND_BIT];
  assign pf_immediate = event_group_setup[FAIL_IMMEDIATE_BIT];

  assign adaptive_loop_response = loop_tuning[LOOP_ENABLE_BIT];
  assign loop_residual = loop_tuning[LOOP_RESIDUAL_LSB +: LOOP_RESIDUAL_W];
  assign loop_gain = loop_tuning[LOOP_GAIN_LSB +: LOOP_GAIN_W];
  assign track_enable = voltage_follow_setup[2];
  assign track_half_ratio = voltage_follow_setup[1];
  assign track_limit_pin = voltage_follow_setup[0];

  ////////////////////////////////////////////////////////////////////////////
  // Control pin synchroniser
  logic ctrl_meta, ctrl_sync;
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_meta <= 1'b0;
      ctrl_sync <= 1'b0;
    end else if (ce) begin
      ctrl_meta <= ctrl_pin;
      ctrl_sync <= ctrl_meta;
    end
  end

  logic enable_active;
  assign enable_active = (!use_pin || ctrl_sync) &&
                         (!use_operation || operation_on);

  ////////////////////////////////////////////////////////////////////////////
  // Received event decode
  logic rx_pg, rx_down, rx_fail;
  assign rx_pg = rx_valid && rx_event.kind == EV_POWER_GOOD &&
                 pre_en && rx_event.data == pre_id;
  assign rx_down = rx_valid && rx_event.kind == EV_POWER_DOWN &&
                   seq_en && rx_event.data == seq_id;
  // Share peers bypass the group match
  assign rx_fail = rx_valid && rx_event.kind == EV_POWER_FAIL &&
                   (rx_event.data == pf_group ||
                    (share_member && rx_event.share_peer));

  always_ff @(posedge clk) begin
    if (rst) begin
      setpoint_hit <= 1'b0;
      operation_hit <= 1'b0;
    end else if (ce) begin
      setpoint_hit <= rx_valid && rx_event.kind == EV_SETPOINT &&
                      sp_respond && rx_event.data == sp_group;
      operation_hit <= rx_valid && rx_event.kind == EV_OPERATION &&
                       op_respond && rx_event.data == op_group;
    end
  end

  // Prequel good is remembered until the local enable drops
  logic pg_seen;
  always_ff @(posedge clk) begin
    if (rst) begin
      pg_seen <= 1'b0;
    end else if (ce) begin
      if (rx_pg) begin
        pg_seen <= 1'b1;
      end else if (!enable_active) begin
        pg_seen <= 1'b0;
      end
    end
  end

  // Holds the rail off after a shutdown event until enable is cycled,
  // otherwise a still-latched prequel good would restart it at once
  logic off_lock;
  always_ff @(posedge clk) begin
    if (rst) begin
      off_lock <= 1'b0;
    end else if (ce) begin
      if (rx_fail || rx_down) begin
        off_lock <= 1'b1;
      end else if (!enable_active) begin
        off_lock <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output sequencing
  typedef enum logic [1:0] {
    ST_OFF,
    ST_ON,
    ST_STOP
  } rail_state_type;

  rail_state_type state;
  logic timer_start, timer_done, going_off, going_on, kill_now, stop_req;
  assign kill_now = rx_fail && pf_immediate;
  assign stop_req = rx_down || !enable_active ||
                    (rx_fail && !pf_immediate);
  assign going_on = state == ST_OFF && enable_active && !off_lock &&
                    (!pre_en || pg_seen);
  assign timer_start = state == ST_ON && !kill_now && stop_req;
  assign going_off = (state != ST_OFF) &&
                     (kill_now || (state == ST_STOP && timer_done));
  hold_timer #(
    .W(OFF_DELAY_W)
  ) off_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(timer_start),
    .abort(kill_now),
    .load(off_delay),
    .busy(),
    .done(timer_done)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_OFF;
    end else if (ce) begin
      case (state)
        ST_OFF: state <= going_on ? ST_ON : ST_OFF;
        ST_ON: begin
          if (kill_now) begin
            state <= ST_OFF;
          end else if (stop_req) begin
            state <= ST_STOP;
          end
        end
        ST_STOP: state <= going_off ? ST_OFF : ST_STOP;
        default: state <= ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      output_on <= 1'b0;
      fast_off <= 1'b0;
    end else if (ce) begin
      fast_off <= kill_now && state != ST_OFF;
      if (going_on) begin
        output_on <= 1'b1;
      end else if (going_off) begin
        output_on <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit queue: one pending flag per kind, lowest index first.
  // A new request in the cycle its flag is sent is kept, not lost.
  logic [EVENT_KINDS-1:0] pend, req, grant;
  // Bit order follows the event kind codes
  assign req = {send_operation, send_setpoint, send_power_fail, going_off,
                going_on};
  always_comb begin
    grant = '0;
    for (int i = 0; i < EVENT_KINDS; i++) begin
      if (pend[i] && grant == '0) begin
        grant[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend <= '0;
    end else if (ce) begin
      pend <= (pend & ~grant) | req;
    end
  end

  logic [4:0] next_tx_data;
  event_kind_type next_tx_kind;
  always_comb begin
    next_tx_kind = EV_POWER_GOOD;
    next_tx_data = own_rail_id;
    if (grant[EV_POWER_DOWN]) begin
      next_tx_kind = EV_POWER_DOWN;
    end else if (grant[EV_POWER_FAIL]) begin
      next_tx_kind = EV_POWER_FAIL;
      next_tx_data = pf_group;
    end else if (grant[EV_SETPOINT]) begin
      next_tx_kind = EV_SETPOINT;
      next_tx_data = sp_group;
    end else if (grant[EV_OPERATION]) begin
      next_tx_kind = EV_OPERATION;
      next_tx_data = op_group;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_event <= '0;
    end else if (ce) begin
      tx_valid <= grant != '0;
      if (grant != '0) begin
        tx_event.kind <= next_tx_kind;
        tx_event.data <= next_tx_data;
        // Lets share peers follow a local fail whatever their group
        tx_event.share_peer <= share_member;
      end
    end
  end

endmodule : rail_sequence_group_config
`default_nettype wire

// [rail_seq_properties.sv]
// Purpose: Port checker for the rail sequence group block.
// Assumes: ce is held high; ctrl_pin is steady around turn-on.
// Notes: Shadow copies of the registers follow the command port.
`timescale 1ns/1ns
`default_nettype none
module rail_seq_properties
  import rail_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] cmd_wdata,
  input wire logic rd_valid,
  input wire logic [31:0] rd_data,
  input wire logic cmd_unmapped,
  // Enables and identity
  input wire logic ctrl_pin,
  input wire logic use_pin,
  input wire logic use_operation,
  input wire logic operation_on,
  input wire logic [4:0] own_rail_id,
  input wire logic share_member,
  // Event bus
  input wire logic rx_valid,
  input wire bus_event_type rx_event,
  input wire logic tx_valid,
  input wire bus_event_type tx_event,
  // Results
  input wire logic output_on,
  input wire logic fast_off,
  input wire logic setpoint_hit,
  input wire logic operation_hit,
  input wire logic adaptive_loop_response,
  input wire logic [LOOP_RESIDUAL_W-1:0] loop_residual,
  input wire logic [LOOP_GAIN_W-1:0] loop_gain,
  input wire logic track_enable,
  input wire logic track_half_ratio,
  input wire logic track_limit_pin
);
  logic [31:0] lt, ro, vf, eg, exp_rd;
  logic [4:0] exp_tx;
  logic known, lcl_en, pf_m;
  assign known = cmd_code inside {CMD_LOOP_TUNING, CMD_RAIL_ORDER,
    CMD_VOLTAGE_FOLLOW_SETUP, CMD_EVENT_GROUP_SETUP};
  assign lcl_en = (!use_pin || ctrl_pin) && (!use_operation || operation_on);
  assign pf_m = rx_event.data == eg[4:0] ||
    (share_member && rx_event.share_peer);
  always_ff @(posedge clk) begin
    if (rst) begin
      lt <= 32'h0;
      ro <= 32'h0;
      vf <= 32'h0;
      eg <= 32'h0;
    end else if (cmd_valid && cmd_write) begin
      if (cmd_code == CMD_LOOP_TUNING) lt <= cmd_wdata & 32'h01FFFFFF;
      if (cmd_code == CMD_RAIL_ORDER) ro <= cmd_wdata & 32'h00009F9F;
      if (cmd_code == CMD_VOLTAGE_FOLLOW_SETUP) vf <= cmd_wdata & 32'h86;
      if (cmd_code == CMD_EVENT_GROUP_SETUP) eg <= cmd_wdata & 32'h003F3F3F;
    end
  end
  always_comb begin
    case (cmd_code)
      CMD_LOOP_TUNING: exp_rd = lt;
      CMD_RAIL_ORDER: exp_rd = ro;
      CMD_VOLTAGE_FOLLOW_SETUP: exp_rd = vf;
      default: exp_rd = eg;
    endcase
    case (tx_event.kind)
      EV_SETPOINT: exp_tx = eg[20:16];
      EV_OPERATION: exp_tx = eg[12:8];
      EV_POWER_FAIL: exp_tx = eg[4:0];
      default: exp_tx = own_rail_id;
    endcase
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_stays_on;
    output_on [*2];
  endsequence
  sequence s_pg_rise;
    !output_on ##1 output_on;
  endsequence
  AST_RD_DATA: assert property (
    cmd_valid && !cmd_write && known |=> rd_valid && rd_data == $past(exp_rd))
    else $error("read data differs from register");
  AST_UNMAPPED: assert property (
    cmd_valid |=> cmd_unmapped == !$past(known))
    else $error("unmapped flag wrong");
  AST_LOOP_OUT: assert property (
    cmd_valid && cmd_write && cmd_code == CMD_LOOP_TUNING |=>
    {adaptive_loop_response, loop_residual, loop_gain} ==
    $past(cmd_wdata[24:0]))
    else $error("loop settings not taken");
  AST_TRACK_OUT: assert property (
    cmd_valid && cmd_write && cmd_code == CMD_VOLTAGE_FOLLOW_SETUP |=>
    {track_enable, track_half_ratio, track_limit_pin} ==
    {$past(cmd_wdata[7]), $past(cmd_wdata[2]), $past(cmd_wdata[1])})
    else $error("tracking settings not taken");
  AST_SP_HIT: assert property (
    rx_valid && rx_event.kind == EV_SETPOINT |=>
    setpoint_hit == $past(eg[21] && rx_event.data == eg[20:16]))
    else $error("setpoint acceptance wrong");
  AST_OP_HIT: assert property (
    rx_valid && rx_event.kind == EV_OPERATION |=>
    operation_hit == $past(eg[13] && rx_event.data == eg[12:8]))
    else $error("operation acceptance wrong");
  AST_FAST_OFF: assert property (
    rx_valid && rx_event.kind == EV_POWER_FAIL && pf_m && eg[5] && output_on
    |=> !output_on && fast_off)
    else $error("immediate shutdown missing");
  AST_SEQ_FAIL: assert property (
    rx_valid && rx_event.kind == EV_POWER_FAIL && pf_m && !eg[5] && output_on
    |=> !fast_off && output_on)
    else $error("sequenced shutdown cut short");
  AST_DOWN_DELAY: assert property (
    rx_valid && rx_event.kind == EV_POWER_DOWN && ro[7] &&
    rx_event.data == ro[4:0] && output_on |=> s_stays_on)
    else $error("turn-off delay skipped");
  AST_PG_ON: assert property (
    rx_valid && rx_event.kind == EV_POWER_GOOD && ro[15] &&
    rx_event.data == ro[12:8] && lcl_en && !output_on |=> s_pg_rise)
    else $error("output did not follow prequel good");
  AST_ON_NEEDS_EN: assert property (
    $rose(output_on) |-> $past(lcl_en))
    else $error("output on without local enable");
  AST_TX_DATA: assert property (
    tx_valid |-> tx_event.data == exp_tx &&
    tx_event.share_peer == share_member)
    else $error("sent event data wrong");
endmodule : rail_seq_properties
bind rail_sequence_group_config rail_seq_properties chk (.clk, .rst,
  .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .rd_valid, .rd_data,
  .cmd_unmapped, .ctrl_pin, .use_pin, .use_operation, .operation_on,
  .own_rail_id, .share_member, .rx_valid, .rx_event, .tx_valid, .tx_event,
  .output_on, .fast_off, .setpoint_hit, .operation_hit,
  .adaptive_loop_response, .loop_residual, .loop_gain, .track_enable,
  .track_half_ratio, .track_limit_pin);
`default_nettype wire

// [rail_peer_model.sv]
// Purpose: Peer rail that places events on the shared event bus.
// Assumes: One event per call, launched just after a rising edge.
// Notes: An idle bus shows the inverted last event, never a stale one.
`timescale 1ns/1ns
`default_nettype none
module rail_peer_model
  import rail_seq_pkg::*;
(
  // Clock
  input wire logic clk,
  // Event bus toward the device
  output logic rx_valid,
  output bus_event_type rx_event
);
  initial begin
    rx_valid = 1'b0;
    rx_event = '0;
  end
  task automatic send(input event_kind_type k, input logic [4:0] d,
    input logic sp);
    @(posedge clk);
    #1;
    rx_valid = 1'b1;
    rx_event = '{k, d, sp};
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_event = bus_event_type'(~rx_event);
  endtask : send
endmodule : rail_peer_model
`default_nettype wire

// [test_rail_sequence_group_config.sv]
// Purpose: Self-checking bench for the rail sequence group block.
// Assumes: ce held high, fixed own rail id.
// Notes: All drives happen 1 ns after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module test_rail_sequence_group_config
  import rail_seq_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_write = 1'b0;
  logic ctrl_pin = 1'b0, share_member = 1'b0, got_rv, got_um;
  logic use_op = 1'b0, op_on = 1'b0;
  logic [2:0] send_req = 3'h0;
  logic [7:0] cmd_code = 8'h00;
  logic [31:0] cmd_wdata = 32'h0, got_rd;
  logic [15:0] off_delay = 16'h0004;
  logic rd_valid, cmd_unmapped, rx_valid, tx_valid, output_on, fast_off;
  logic setpoint_hit, operation_hit, adaptive_loop_response;
  logic track_enable, track_half_ratio, track_limit_pin;
  logic [31:0] rd_data;
  logic [7:0] loop_residual;
  logic [15:0] loop_gain;
  logic [7:0] codes [4] = '{CMD_LOOP_TUNING, CMD_RAIL_ORDER,
    CMD_VOLTAGE_FOLLOW_SETUP, CMD_EVENT_GROUP_SETUP};
  logic [31:0] masks [4] = '{32'h01FFFFFF, 32'h00009F9F, 32'h00000086,
    32'h003F3F3F};
  bus_event_type rx_event, tx_event;
  int bad_count = 0, n_checks = 0, n;
  rail_sequence_group_config uut (.clk(clk), .rst(rst), .ce(1'b1),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
    .cmd_unmapped(cmd_unmapped), .ctrl_pin(ctrl_pin), .use_pin(1'b1),
    .use_operation(use_op), .operation_on(op_on), .own_rail_id(5'h0A),
    .share_member(share_member), .off_delay(off_delay),
    .rx_valid(rx_valid), .rx_event(rx_event),
    .send_setpoint(send_req[0]), .send_operation(send_req[1]),
    .send_power_fail(send_req[2]), .tx_valid(tx_valid),
    .tx_event(tx_event), .output_on(output_on), .fast_off(fast_off),
    .setpoint_hit(setpoint_hit), .operation_hit(operation_hit),
    .adaptive_loop_response(adaptive_loop_response),
    .loop_residual(loop_residual), .loop_gain(loop_gain),
    .track_enable(track_enable), .track_half_ratio(track_half_ratio),
    .track_limit_pin(track_limit_pin));
  rail_peer_model peer (.clk(clk), .rx_valid(rx_valid),
    .rx_event(rx_event));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  // Snapshot before the extra tick, since the answer stands one cycle
  task automatic cmd(input logic w, input logic [7:0] c,
    input logic [31:0] d);
    {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b1, w, c, d};
    tick(1);
    cmd_valid = 1'b0;
    {got_rv, got_um, got_rd} = {rd_valid, cmd_unmapped, rd_data};
    tick(1);
  endtask : cmd
  task automatic rd(input logic [7:0] c, input logic [31:0] exp);
    cmd(1'b0, c, 32'h0);
    chk(32'(got_rv), 32'h1);
    chk(got_rd, exp);
  endtask : rd
  task automatic wait_on(input logic lvl);
    n = 0;
    while (output_on !== lvl && n < 50) begin
      tick(1);
      n++;
    end
    chk(32'(output_on), 32'(lvl));
  endtask : wait_on
  task automatic recycle;
    ctrl_pin = 1'b0;
    wait_on(1'b0);
    tick(2);
    ctrl_pin = 1'b1;
    wait_on(1'b1);
  endtask : recycle
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    bad_count++;
    $display("watchdog expired");
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] tv [3] = '{8'h80, 8'h04, 8'h02};
    event_kind_type ek [6] = '{EV_SETPOINT, EV_SETPOINT, EV_OPERATION,
      EV_OPERATION, EV_SETPOINT, EV_OPERATION};
    logic [4:0] ed [6] = '{5'd9, 5'd8, 5'd4, 5'd9, 5'd9, 5'd4};
    logic [1:0] eh [6] = '{2'b10, 2'b00, 2'b01, 2'b00, 2'b00, 2'b00};
    tick(6);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(codes[i], 32'h0);
      cmd(1'b1, codes[i], 32'hFFFFFFFF);
      rd(codes[i], masks[i]);
    end
    cmd(1'b0, 8'hE3, 32'h0);
    chk(32'(got_um), 32'h1);
    chk(got_rd, 32'h0);
    cmd(1'b1, 8'hE3, 32'h0);
    rd(CMD_RAIL_ORDER, 32'h00009F9F);
    $display("test registers done");
    cmd(1'b1, CMD_LOOP_TUNING, 32'h01A51234);
    chk(32'({adaptive_loop_response, loop_residual, loop_gain}),
      32'h01A51234);
    cmd(1'b1, CMD_LOOP_TUNING, 32'h00A51234);
    chk(32'(adaptive_loop_response), 32'h0);
    for (int i = 0; i < 3; i++) begin
      cmd(1'b1, CMD_VOLTAGE_FOLLOW_SETUP, 32'(tv[i]));
      chk(32'({track_enable, track_half_ratio, track_limit_pin}),
        32'(3'b100 >> i));
    end
    $display("test settings done");
    cmd(1'b1, CMD_EVENT_GROUP_SETUP, 32'h0);
    cmd(1'b1, CMD_RAIL_ORDER, 32'h00000085);
    ctrl_pin = 1'b1;
    wait_on(1'b1);
    peer.send(EV_POWER_DOWN, 5'd6, 1'b0);
    tick(3);
    chk(32'(output_on), 32'h1);
    peer.send(EV_POWER_DOWN, 5'd5, 1'b0);
    wait_on(1'b0);
    chk(n, 32'(off_delay) + 2);
    recycle();
    cmd(1'b1, CMD_RAIL_ORDER, 32'h00008300);
    ctrl_pin = 1'b0;
    wait_on(1'b0);
    ctrl_pin = 1'b1;
    tick(6);
    chk(32'(output_on), 32'h0);
    peer.send(EV_POWER_GOOD, 5'd2, 1'b0);
    tick(2);
    chk(32'(output_on), 32'h0);
    peer.send(EV_POWER_GOOD, 5'd3, 1'b0);
    chk(32'(output_on), 32'h0);
    tick(1);
    chk(32'(output_on), 32'h1);
    $display("test sequencing done");
    cmd(1'b1, CMD_RAIL_ORDER, 32'h0);
    cmd(1'b1, CMD_EVENT_GROUP_SETUP, 32'h00000027);
    peer.send(EV_POWER_FAIL, 5'd8, 1'b1);
    tick(2);
    chk(32'(output_on), 32'h1);
    share_member = 1'b1;
    peer.send(EV_POWER_FAIL, 5'd8, 1'b1);
    chk(32'({output_on, fast_off}), 32'h1);
    recycle();
    cmd(1'b1, CMD_EVENT_GROUP_SETUP, 32'h00000007);
    peer.send(EV_POWER_FAIL, 5'd7, 1'b0);
    chk(32'(fast_off), 32'h0);
    wait_on(1'b0);
    chk(n, 32'(off_delay) + 2);
    recycle();
    use_op = 1'b1;
    wait_on(1'b0);
    op_on = 1'b1;
    wait_on(1'b1);
    $display("test power fail done");
    cmd(1'b1, CMD_EVENT_GROUP_SETUP, 32'h00292413);
    for (int i = 0; i < 6; i++) begin
      // from the fifth event on both respond bits are cleared, so neither hit fires
      if (i == 4) cmd(1'b1, CMD_EVENT_GROUP_SETUP, 32'h00090413);
      peer.send(ek[i], ed[i], 1'b0);
      chk(32'({setpoint_hit, operation_hit}), 32'(eh[i]));
    end
    for (int k = 0; k < 3; k++) begin
      send_req = 3'(1 << k);
      tick(1);
      send_req = 3'h0;
      tick(1);
      chk(32'(tx_valid), 32'h1);
      chk(32'(tx_event), 32'({k == 2 ? EV_POWER_FAIL : ek[2 * k],
        k == 0 ? 5'd9 : k == 1 ? 5'd4 : 5'h13, 1'b1}));
      tick(2);
    end
    $display("test broadcast done");
    tally_and_finish();
  end
endmodule : test_rail_sequence_group_config
`default_nettype wire
